//--- logic/imh_pkg.sv
// Constants, types and register map of the I2C hardware master
package imh_pkg;
  localparam logic [23:0] OFF_ADDR = 24'h10_3400;
  localparam logic [23:0] OFF_DATA = 24'h10_3404;
  localparam logic [23:0] OFF_STAT = 24'h10_3408;
  localparam logic [23:0] OFF_CTRL = 24'h10_340C;
  localparam int CTL_EN = 0;
  localparam int CTL_CLR = 22;
  localparam int CTL_IEN = 28;
  localparam int AR_CNT = 8;
  localparam int AR_DIR = 24;
  localparam int AR_SADDR = 25;
  localparam int SR_SCL = 0;
  localparam int SR_SDA = 1;
  localparam int SR_DIR = 4;
  localparam int SR_STATE = 5;
  localparam int SR_RBC = 8;
  localparam int SR_FLAG = 28;
  localparam int F_SDNACK = 0;
  localparam int F_SANACK = 1;
  localparam int F_REQ = 2;
  localparam int F_DONE = 3;
  localparam logic [2:0] CODE_IDLE = 3'h0;
  localparam logic [2:0] CODE_START = 3'h1;
  localparam logic [2:0] CODE_XFER = 3'h2;
  localparam logic [2:0] CODE_HOLD = 3'h3;
  localparam logic [2:0] CODE_STOP = 3'h4;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int QW = 9;
  localparam logic [10:0] DIV_STD [4] = '{11'h3F0, 11'h2F0, 11'h200, 11'h150};
  localparam logic [10:0] DIV_FAST [4] = '{11'h100, 11'h0C0, 11'h080, 11'h060};

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_XFER, ST_HOLD, ST_STOP} imh_state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [23:0] address;
    logic [31:0] writedata;
  } imh_avs_req_s;

  typedef struct packed {
    imh_state_e st;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [1:0] bidx;
    logic [7:0] remaining_count;
    logic is_addr;
    logic armed;
    logic en;
    logic [3:0] ien;
    logic [6:0] saddr;
    logic dir;
    logic [7:0] count;
    logic [31:0] data;
    logic [3:0] flags;
    logic strap_done;
    logic [1:0] boot_sel;
    logic fast;
    logic rd_done;
    logic [31:0] rdata;
    logic scl_oe;
    logic sda_oe;
  } imh_regs_s;

  localparam imh_regs_s REGS_RST = '0;
endpackage

//--- logic/imh_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module imh_sync #(
  parameter logic RST_VAL = 1'h1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pin in, filtered level out
  input wire logic pin,
  output logic level
);
  logic [2:0] stage;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage <= {3{RST_VAL}};
      level <= RST_VAL;
    end else begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end
endmodule

//--- logic/imh_tick.sv
// Quarter-bit tick generator for SCL timing
`timescale 1ns/1ns
module imh_tick #(
  parameter int CW = 9
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control and tick
  input wire logic restart,
  input wire logic [CW-1:0] quarter,
  output logic tick
);
  logic [CW-1:0] cnt;

  if (CW < 8) begin : g_chk
    $error("imh_tick: CW too small for divider");
  end

  assign tick = !restart && (cnt == CW'(quarter - 1'h1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (restart || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'h1;
    end
  end
endmodule

//--- logic/imh_master.sv
// I2C hardware master engine with Avalon-MM register slave
`timescale 1ns/1ns
module imh_master
  import imh_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Boot straps
  input wire logic [1:0] boot_clk_sel,
  input wire logic boot_speed_fast,
  // Register bus
  input wire imh_avs_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // I2C pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  imh_regs_s r;
  imh_regs_s next_r;
  logic scl_f;
  logic sda_f;
  logic tick;
  logic restart;
  logic tx;
  logic bit_end;
  logic ack_end;
  logic nak;
  logic rd_acc;
  logic [1:0] nb;
  logic [3:0] clr;
  logic [3:0] set;
  logic [10:0] div;
  logic [QW-1:0] quarter;

  function automatic logic [2:0] code_of(imh_state_e s);
    case (s)
      ST_IDLE: code_of = CODE_IDLE;
      ST_START: code_of = CODE_START;
      ST_XFER: code_of = CODE_XFER;
      ST_HOLD: code_of = CODE_HOLD;
      ST_STOP: code_of = CODE_STOP;
      default: code_of = CODE_IDLE;
    endcase
  endfunction

  imh_sync u_scl_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin(scl_i),
    .level(scl_f)
  );

  imh_sync u_sda_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin(sda_i),
    .level(sda_f)
  );

  imh_tick #(.CW(QW)) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .restart(restart),
    .quarter(quarter),
    .tick(tick)
  );

  // Divider fixed by straps caught once after reset
  assign div = r.fast ? DIV_FAST[r.boot_sel] : DIV_STD[r.boot_sel];
  assign quarter = QW'(div >> 2);

  // Timer idles outside bit time and waits for SCL high
  assign restart = (r.st == ST_IDLE) || (r.st == ST_HOLD) ||
                   ((r.st == ST_XFER || r.st == ST_STOP) && r.phase == 2'h2 && !scl_f);

  assign tx = !r.dir || r.is_addr;
  assign bit_end = tick && r.st == ST_XFER && r.phase == 2'h3;
  assign ack_end = bit_end && r.bitn == ACK_BIT;
  assign nak = sda_f;
  assign rd_acc = avs_req.read && !r.rd_done;
  assign nb = r.bidx + 2'h1;

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = rd_acc;
  assign scl_o = 1'h0;
  assign sda_o = 1'h0;
  assign scl_oe = r.scl_oe;
  assign sda_oe = r.sda_oe;

  always_comb begin
    next_r = r;
    clr = '0;
    set = '0;
    next_r.rd_done = rd_acc;
    if (!r.strap_done) begin
      next_r.strap_done = 1'h1;
      next_r.boot_sel = boot_clk_sel;
      next_r.fast = boot_speed_fast;
    end
    // Register reads; data read may release a held read
    if (rd_acc) begin
      next_r.rdata = '0;
      case (avs_req.address)
        OFF_CTRL: begin
          // Software pin mode bit always reads 0
          next_r.rdata[CTL_IEN+:4] = r.ien;
          next_r.rdata[CTL_EN] = r.en;
        end
        OFF_ADDR: begin
          next_r.rdata[AR_SADDR+:7] = r.saddr;
          next_r.rdata[AR_DIR] = r.dir;
          next_r.rdata[AR_CNT+:8] = r.count;
        end
        OFF_DATA: begin
          next_r.rdata = r.data;
          if (r.st == ST_HOLD && r.dir) begin
            next_r.st = ST_XFER;
            next_r.phase = 2'h0;
            next_r.bitn = 4'h0;
            next_r.bidx = 2'h0;
            next_r.data = '0;
          end
        end
        OFF_STAT: begin
          next_r.rdata[SR_FLAG+:4] = r.flags;
          next_r.rdata[SR_RBC+:8] = r.remaining_count;
          next_r.rdata[SR_STATE+:3] = code_of(r.st);
          next_r.rdata[SR_DIR] = r.dir;
          next_r.rdata[SR_SDA] = !sda_f;
          next_r.rdata[SR_SCL] = !scl_f;
        end
        default: begin
          next_r.rdata = '0;
        end
      endcase
    end
    // Register writes
    if (avs_req.write) begin
      case (avs_req.address)
        OFF_CTRL: begin
          next_r.en = avs_req.writedata[CTL_EN];
          next_r.ien = avs_req.writedata[CTL_IEN+:4];
          clr = avs_req.writedata[CTL_CLR+:4];
        end
        OFF_ADDR: begin
          if (r.st == ST_IDLE) begin
            next_r.saddr = avs_req.writedata[AR_SADDR+:7];
            next_r.dir = avs_req.writedata[AR_DIR];
            next_r.count = avs_req.writedata[AR_CNT+:8];
            next_r.remaining_count = avs_req.writedata[AR_CNT+:8];
            next_r.armed = !avs_req.writedata[AR_DIR];
            if (r.en && avs_req.writedata[AR_DIR]) begin
              next_r.st = ST_START;
              next_r.phase = 2'h0;
              next_r.is_addr = 1'h1;
              next_r.bidx = 2'h0;
              next_r.shift = {avs_req.writedata[AR_SADDR+:7], 1'h1};
            end
          end
        end
        OFF_DATA: begin
          if (!r.dir || r.st == ST_IDLE) begin
            next_r.data = avs_req.writedata;
          end
          if (r.en && !r.dir && r.armed && r.st == ST_IDLE) begin
            next_r.st = ST_START;
            next_r.phase = 2'h0;
            next_r.is_addr = 1'h1;
            next_r.armed = 1'h0;
            next_r.bidx = 2'h0;
            next_r.shift = {r.saddr, 1'h0};
          end else if (r.st == ST_HOLD && !r.dir) begin
            next_r.st = ST_XFER;
            next_r.phase = 2'h0;
            next_r.bitn = 4'h0;
            next_r.bidx = 2'h0;
            next_r.shift = avs_req.writedata[31:24];
          end
        end
        default: begin
        end
      endcase
    end
    // Bus engine, advanced one quarter bit per tick
    if (tick) begin
      case (r.st)
        ST_START: begin
          if (r.phase == 2'h3) begin
            next_r.st = ST_XFER;
            next_r.phase = 2'h0;
            next_r.bitn = 4'h0;
          end else begin
            next_r.phase = r.phase + 2'h1;
          end
        end
        ST_XFER: begin
          if (r.phase != 2'h3) begin
            next_r.phase = r.phase + 2'h1;
          end else begin
            next_r.phase = 2'h0;
            if (r.bitn != ACK_BIT) begin
              next_r.shift = {r.shift[6:0], sda_f};
              next_r.bitn = r.bitn + 4'h1;
            end else begin
              next_r.bitn = 4'h0;
              if (tx) begin
                if (nak) begin
                  // Slave refused: stop, nothing more sent
                  set[r.is_addr ? F_SANACK : F_SDNACK] = 1'h1;
                  next_r.st = ST_STOP;
                end else if (r.is_addr) begin
                  next_r.is_addr = 1'h0;
                  if (r.remaining_count == 8'h00) begin
                    set[F_DONE] = 1'h1;
                    next_r.st = ST_STOP;
                  end else if (!r.dir) begin
                    next_r.shift = r.data[31:24];
                  end
                end else begin
                  next_r.remaining_count = r.remaining_count - 8'h01;
                  if (r.remaining_count == 8'h01) begin
                    set[F_DONE] = 1'h1;
                    next_r.st = ST_STOP;
                  end else if (r.bidx == 2'h3) begin
                    set[F_REQ] = 1'h1;
                    next_r.st = ST_HOLD;
                  end else begin
                    next_r.bidx = nb;
                    next_r.shift = 8'(r.data >> {~nb, 3'h0});
                  end
                end
              end else begin
                next_r.data[{~r.bidx, 3'h0}+:8] = r.shift;
                next_r.remaining_count = r.remaining_count - 8'h01;
                if (r.remaining_count == 8'h01) begin
                  set[F_DONE] = 1'h1;
                  set[F_REQ] = 1'h1;
                  next_r.st = ST_STOP;
                end else if (r.bidx == 2'h3) begin
                  set[F_REQ] = 1'h1;
                  next_r.st = ST_HOLD;
                end else begin
                  next_r.bidx = nb;
                end
              end
            end
          end
        end
        ST_STOP: begin
          if (r.phase == 2'h3) begin
            next_r.st = ST_IDLE;
            next_r.phase = 2'h0;
          end else begin
            next_r.phase = r.phase + 2'h1;
          end
        end
        default: begin
        end
      endcase
    end
    // New events win over a clear in the same cycle
    next_r.flags = (r.flags & ~clr) | set;
    // Enable low holds the whole interface except the ien bits in reset
    if (!r.en) begin
      next_r.st = ST_IDLE;
      next_r.phase = 2'h0;
      next_r.bitn = 4'h0;
      next_r.bidx = 2'h0;
      next_r.shift = 8'h00;
      next_r.remaining_count = 8'h00;
      next_r.is_addr = 1'h0;
      next_r.armed = 1'h0;
      next_r.saddr = 7'h00;
      next_r.dir = 1'h0;
      next_r.count = 8'h00;
      next_r.data = '0;
      next_r.flags = 4'h0;
    end
    // Open-drain drive from the next state; SDA moves a quarter after SCL falls
    case (next_r.st)
      ST_START: begin
        next_r.scl_oe = next_r.phase == 2'h3;
        next_r.sda_oe = next_r.phase != 2'h0;
      end
      ST_XFER: begin
        next_r.scl_oe = next_r.phase < 2'h2;
        if (next_r.phase == 2'h0) begin
          next_r.sda_oe = r.sda_oe;
        end else if (next_r.bitn != ACK_BIT) begin
          next_r.sda_oe = (!next_r.dir || next_r.is_addr) && !next_r.shift[7];
        end else begin
          next_r.sda_oe = !(!next_r.dir || next_r.is_addr) && next_r.remaining_count != 8'h01;
        end
      end
      ST_HOLD: begin
        next_r.scl_oe = 1'h1;
        next_r.sda_oe = 1'h0;
      end
      ST_STOP: begin
        next_r.scl_oe = next_r.phase < 2'h2;
        next_r.sda_oe = (next_r.phase == 2'h0) ? r.sda_oe : (next_r.phase != 2'h3);
      end
      default: begin
        next_r.scl_oe = 1'h0;
        next_r.sda_oe = 1'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  a_nak_stop: assert property (@(posedge core_clk) disable iff (rst)
    (ack_end && tx && nak && r.en) |=> (r.st == ST_STOP && code_of(r.st) == CODE_STOP))
    else $error("NAK did not lead to STOP");

  a_tx_ack_free: assert property (@(posedge core_clk) disable iff (rst)
    (r.st == ST_XFER && r.bitn == ACK_BIT && r.phase != 2'h0 && tx) |-> !r.sda_oe)
    else $error("SDA driven during slave acknowledge");

  a_rx_last_nak: assert property (@(posedge core_clk) disable iff (rst)
    (r.st == ST_XFER && r.bitn == ACK_BIT && r.phase != 2'h0 && !tx) |-> (r.sda_oe == (r.remaining_count != 8'h01)))
    else $error("Wrong master acknowledge");

  a_addr_dir_bit: assert property (@(posedge core_clk) disable iff (rst)
    (r.st == ST_XFER && r.is_addr && r.bitn == 4'h7 && r.phase != 2'h0) |-> (r.sda_oe == !r.dir))
    else $error("Address LSB does not match direction");

  a_stretch_wait: assert property (@(posedge core_clk) disable iff (rst)
    (r.en && r.st == ST_XFER && r.phase == 2'h2 && !scl_f) |=> (r.phase == 2'h2 && !r.scl_oe))
    else $error("High phase left while SCL held low");

  a_stop_release: assert property (@(posedge core_clk) disable iff (rst)
    (r.en && tick && r.st == ST_STOP && r.phase == 2'h3) |=> (r.st == ST_IDLE && !r.scl_oe && !r.sda_oe))
    else $error("STOP did not release the bus");

  a_disable_clears: assert property (@(posedge core_clk) disable iff (rst)
    !r.en |=> (r.st == ST_IDLE && r.flags == 4'h0 && r.remaining_count == 8'h00))
    else $error("Enable low did not reset interface");

  a_hold_request: assert property (@(posedge core_clk) disable iff (rst)
    (r.st == ST_XFER ##1 r.st == ST_HOLD) |-> (r.flags[F_REQ] && r.scl_oe))
    else $error("Hold without data request");

  a_count_step: assert property (@(posedge core_clk) disable iff (rst)
    (r.en && ack_end && !r.is_addr && !(tx && nak)) |=> (r.remaining_count == $past(r.remaining_count) - 8'h01))
    else $error("Remaining count did not step");

  a_read_starts: assert property (@(posedge core_clk) disable iff (rst)
    (r.en && r.st == ST_IDLE && avs_req.write && avs_req.address == OFF_ADDR && avs_req.writedata[AR_DIR])
    |=> (r.st == ST_START && r.is_addr) ##1 (r.st == ST_START && !r.scl_oe))
    else $error("Read address write did not start");

  a_write_starts: assert property (@(posedge core_clk) disable iff (rst)
    (r.en && r.st == ST_IDLE && r.armed && !r.dir && avs_req.write && avs_req.address == OFF_DATA)
    |=> (r.st == ST_START && r.shift[0] == 1'h0))
    else $error("Data write did not start a write");
endmodule

//--- verification/imh_slave_model.sv
// Behavioural I2C slave that acks its address, stores writes and serves reads
`timescale 1ns/1ns
module imh_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Wire levels in
  input wire logic scl,
  input wire logic sda,
  // Pull-down drives and test control
  output logic scl_pull,
  output logic sda_pull,
  input wire logic stretch
);
  logic [7:0] rx_q [$];
  logic ack_q [$];
  logic [7:0] b;
  logic [7:0] tx;
  int i;
  task automatic get();
    for (int k = 0; k < 8; k++) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    rx_q.push_back(b);
  endtask
  task automatic ack();
    @(negedge scl);
    sda_pull = 1'b1;
    @(negedge scl);
    sda_pull = 1'b0;
    if (stretch) begin
      scl_pull = 1'b1;
      #3000;
      scl_pull = 1'b0;
    end
  endtask
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    tx = 8'hC0;
    forever begin
      @(negedge sda iff scl);
      fork
        begin
          get();
          if (b[7:1] != ADDR) wait (0);
          ack();
          if (!b[0]) forever begin
            get();
            ack();
          end
          forever begin
            for (i = 7; i >= 0; i--) begin
              sda_pull = !tx[i];
              @(negedge scl);
            end
            sda_pull = 1'b0;
            @(posedge scl);
            ack_q.push_back(sda);
            tx = tx + 8'h01;
            if (sda) wait (0);
            @(negedge scl);
          end
        end
        @(posedge sda iff scl);
      join_any
      disable fork;
      sda_pull = 1'b0;
      scl_pull = 1'b0;
    end
  end
endmodule

//--- verification/i2c_master_hw_engine_tb.sv
// Self-checking bench for the I2C hardware master
`timescale 1ns/1ns
module i2c_master_hw_engine_tb;
  import imh_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  imh_avs_req_s req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
  logic stretch = 1'b0;
  wire scl = !(scl_oe || scl_pull);
  wire sda = !(sda_oe || sda_pull);
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] s;
  always #5 core_clk = ~core_clk;
  imh_master DUT (.core_clk(core_clk), .rst(rst), .boot_clk_sel(2'b11), .boot_speed_fast(1'b1),
    .avs_req(req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  imh_slave_model slv (.scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull), .stretch(stretch));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic rd, input logic [23:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    req <= '{read: rd, write: !rd, address: a, writedata: d};
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata;
    req <= '0;
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [23:0] a, output logic [31:0] q);
    bus(1'b1, a, 32'h0000_0000, q);
  endtask
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int k;
    for (k = 0; k < 5000; k++) begin
      rd(OFF_STAT, s);
      if ((s & m) === v) break;
    end
    chk("status wait", k < 5000, 32'h0000_0001);
  endtask
  function automatic logic [31:0] aval(input logic [6:0] sa, input logic dir, input logic [7:0] cnt);
    return {sa, dir, 8'h00, cnt, 8'h00};
  endfunction
  task automatic t_reset();
    rd(OFF_CTRL, s);
    chk("ctrl reset", s, 32'h0000_0000);
    chk("drive level", {scl_o, sda_o}, 2'b00);
    rd(OFF_STAT, s);
    chk("stat reset", s, 32'h0000_0000);
    rd(OFF_CTRL + 24'h00_0010, s);
    chk("unmapped", s, 32'h0000_0000);
    wr(OFF_ADDR, aval(7'h2A, 1'b0, 8'h02));
    wr(OFF_DATA, 32'hAABB_0000);
    repeat (200) @(posedge core_clk);
    chk("no start off", slv.rx_q.size(), 32'h0000_0000);
    rd(OFF_ADDR, s);
    chk("addr held off", s, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_write2();
    wr(OFF_CTRL, 32'h03C0_0001);
    wr(OFF_CTRL, 32'hF000_0001);
    rd(OFF_CTRL, s);
    chk("ctrl ien", s, 32'hF000_0001);
    wr(OFF_ADDR, aval(7'h2A, 1'b0, 8'h02));
    wr(OFF_DATA, 32'hAABB_1234);
    wait_stat(32'h8000_00E0, 32'h8000_0000);
    chk("stat done", s, 32'h8000_0000);
    chk("addr byte", slv.rx_q[0], 8'h54);
    chk("byte 0", slv.rx_q[1], 8'hAA);
    chk("byte 1", slv.rx_q[2], 8'hBB);
    chk("count", slv.rx_q.size(), 32'h0000_0003);
    wr(OFF_CTRL, 32'hF200_0001);
    rd(OFF_STAT, s);
    chk("done clr", s, 32'h0000_0000);
    $display("test write2 done");
  endtask
  task automatic t_write6();
    logic [7:0] e [7] = '{8'h54, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    slv.rx_q.delete();
    stretch = 1'b1;
    wr(OFF_ADDR, aval(7'h2A, 1'b0, 8'h06));
    wr(OFF_DATA, 32'h1122_3344);
    wait_stat(32'h4000_00E1, 32'h4000_0061);
    chk("hold stat", s & 32'hFFFF_FFFD, 32'h4000_0261);
    chk("hold count", slv.rx_q.size(), 32'h0000_0005);
    wr(OFF_CTRL, 32'hF3C0_0001);
    wr(OFF_DATA, 32'h5566_7788);
    wait_stat(32'h8000_00E0, 32'h8000_0000);
    chk("w6 done", s, 32'h8000_0000);
    chk("w6 count", slv.rx_q.size(), 32'h0000_0007);
    for (int k = 0; k < 7; k++) chk("w6 byte", slv.rx_q[k], e[k]);
    stretch = 1'b0;
    wr(OFF_CTRL, 32'hF3C0_0001);
    $display("test write6 done");
  endtask
  task automatic t_read5();
    logic [31:0] q;
    slv.rx_q.delete();
    wr(OFF_ADDR, aval(7'h2A, 1'b1, 8'h05));
    wait_stat(32'h4000_00E1, 32'h4000_0061);
    chk("rd hold", s & 32'hFFFF_FFFD, 32'h4000_0171);
    wr(OFF_CTRL, 32'hF3C0_0001);
    rd(OFF_DATA, q);
    chk("rd chunk0", q, 32'hC0C1_C2C3);
    wait_stat(32'h8000_00E0, 32'h8000_0000);
    chk("rd done", s, 32'hC000_0010);
    rd(OFF_DATA, q);
    chk("rd chunk1", q, 32'hC400_0000);
    chk("rd addr", slv.rx_q[0], 8'h55);
    chk("rd acks", slv.ack_q.size(), 32'h0000_0005);
    for (int k = 0; k < 5; k++) chk("rd ack", slv.ack_q[k], k == 4);
    wr(OFF_CTRL, 32'hF3C0_0001);
    $display("test read5 done");
  endtask
  task automatic t_nak();
    slv.rx_q.delete();
    wr(OFF_ADDR, aval(7'h2B, 1'b0, 8'h02));
    wr(OFF_DATA, 32'hDEAD_0000);
    wait_stat(32'h2000_00E0, 32'h2000_0000);
    repeat (400) @(posedge core_clk);
    rd(OFF_STAT, s);
    chk("nak stat", s & 32'hF000_00FF, 32'h2000_0000);
    chk("nak bytes", slv.rx_q.size(), 32'h0000_0001);
    chk("nak lines", {scl, sda}, 2'b11);
    wr(OFF_CTRL, 32'hF3C0_0001);
    $display("test nak done");
  endtask
  task automatic t_abort();
    wr(OFF_ADDR, aval(7'h2A, 1'b0, 8'h04));
    wr(OFF_DATA, 32'h0102_0304);
    repeat (300) @(posedge core_clk);
    wr(OFF_CTRL, 32'h0000_0000);
    rd(OFF_STAT, s);
    chk("abort stat", s & 32'hFFFF_FFFC, 32'h0000_0000);
    rd(OFF_ADDR, s);
    chk("abort addr", s, 32'h0000_0000);
    chk("abort scl", scl_oe, 1'b0);
    $display("test abort done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_write2();
    t_write6();
    t_read5();
    t_nak();
    t_abort();
    complete_run();
  end
  initial begin
    #900000;
    num_errors++;
    complete_run();
  end
endmodule
